// File: rate_limit_pkg.sv
// constants, field layout and register map of the port rate-limit configuration bank
// ============================================================================
// Function
// - threshold code selects 64k up to 20M rate
// - every threshold field resets to 000 (64k)
// - length bit 0 counts on own port meter
// - four fields per 16-bit register (two for ports 24/25), highest port on top
// - ports 4-7, 8-11, 12-15 share one layout
// - ports 12-15 register at 0x27b, resets zero
// - ports 24/25 register, bits 15:8 reserved
// - per-port enable gates bandwidth control
`default_nettype none

package rate_limit_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned NUM_PORTS = 14;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned THR_W = 3;
  localparam int unsigned FIELD_W = 4;
  localparam int unsigned RATE_W = 15;
  localparam int unsigned EN_HI_W = 10;

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_RATE_4_7 = 10'h279;
  localparam logic [9:0] IDX_RATE_8_11 = 10'h27a;
  localparam logic [9:0] IDX_RATE_12_15 = 10'h27b;
  localparam logic [9:0] IDX_RATE_24_25 = 10'h27c;
  localparam logic [9:0] IDX_ENABLE_LO = 10'h27f;
  localparam logic [9:0] IDX_ENABLE_HI = 10'h280;
  localparam logic [ADDR_W-1:0] ADDR_RATE_4_7 = {IDX_RATE_4_7, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RATE_8_11 = {IDX_RATE_8_11, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RATE_12_15 = {IDX_RATE_12_15, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RATE_24_25 = {IDX_RATE_24_25, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ENABLE_LO = {IDX_ENABLE_LO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ENABLE_HI = {IDX_ENABLE_HI, 2'b00};

  // ==========================================================================
  // field layout inside one four-bit port field
  localparam int unsigned LEN_BIT = 3;
  localparam int unsigned THR_LSB = 0;
  // first bit of the enable low register that belongs to this bank (port 4)
  localparam int unsigned EN_LO_FIRST = 4;
  localparam int unsigned EN_HI_FIRST = 8;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RATE_CFG_RST = 16'h0000;
  localparam logic [7:0] RATE_24_25_RST = 8'h00;
  localparam logic [15:0] ENABLE_LO_RST = 16'h0000;
  localparam logic [EN_HI_W-1:0] ENABLE_HI_RST = 10'h000;
  localparam logic [THR_W-1:0] THR_RST = 3'h0;

  // ==========================================================================
  // threshold codes and the rate each selects, in kbit/s
  localparam logic [THR_W-1:0] THR_64K = 3'h0;
  localparam logic [THR_W-1:0] THR_128K = 3'h1;
  localparam logic [THR_W-1:0] THR_256K = 3'h2;
  localparam logic [THR_W-1:0] THR_512K = 3'h3;
  localparam logic [THR_W-1:0] THR_1M = 3'h4;
  localparam logic [THR_W-1:0] THR_4M = 3'h5;
  localparam logic [THR_W-1:0] THR_10M = 3'h6;
  localparam logic [THR_W-1:0] THR_20M = 3'h7;
  localparam logic [RATE_W-1:0] RATE_64K = 15'h0040;
  localparam logic [RATE_W-1:0] RATE_128K = 15'h0080;
  localparam logic [RATE_W-1:0] RATE_256K = 15'h0100;
  localparam logic [RATE_W-1:0] RATE_512K = 15'h0200;
  localparam logic [RATE_W-1:0] RATE_1M = 15'h03e8;
  localparam logic [RATE_W-1:0] RATE_4M = 15'h0fa0;
  localparam logic [RATE_W-1:0] RATE_10M = 15'h2710;
  localparam logic [RATE_W-1:0] RATE_20M = 15'h4e20;
  localparam logic [RATE_W-1:0] RATE_NONE = 15'h0000;

endpackage : rate_limit_pkg

`default_nettype wire

// File: apb_access.sv
// apb slave phase tracking: setup, access, ready and error answer
`default_nettype none

module apb_access (
  // apb request
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  // decode result
  input wire logic addr_hit_i,
  // phase strobes
  output logic setup_o,
  output logic wr_en_o,
  output logic pready_o,
  output logic pslverr_o
);

  // ==========================================================================
  // zero wait states: every access phase completes at its first edge
  assign pready_o = 1'b1;
  assign setup_o = psel_i && !penable_i;
  // unmapped writes are dropped and flagged
  assign wr_en_o = psel_i && penable_i && pwrite_i && addr_hit_i;
  assign pslverr_o = psel_i && penable_i && !addr_hit_i;

endmodule : apb_access

`default_nettype wire

// File: port_rate_decode.sv
// one port: threshold code to rate, gated by the port's enable
`default_nettype none

module port_rate_decode
  import rate_limit_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // port configuration
  input wire logic [rate_limit_pkg::THR_W-1:0] threshold_i,
  input wire logic enable_i,
  // applied rate, zero while limiting is off
  output logic [rate_limit_pkg::RATE_W-1:0] rate_kbps_o
);

  logic [RATE_W-1:0] rate_reg;
  logic [RATE_W-1:0] rate_next;
  logic [RATE_W-1:0] code_rate;

  // ==========================================================================
  // code table
  always_comb begin
    case (threshold_i)
      THR_64K: code_rate = RATE_64K;
      THR_128K: code_rate = RATE_128K;
      THR_256K: code_rate = RATE_256K;
      THR_512K: code_rate = RATE_512K;
      THR_1M: code_rate = RATE_1M;
      THR_4M: code_rate = RATE_4M;
      THR_10M: code_rate = RATE_10M;
      THR_20M: code_rate = RATE_20M;
      default: code_rate = RATE_64K;
    endcase
  end

  // threshold has no effect while the port is not enabled
  assign rate_next = enable_i ? code_rate : RATE_NONE;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rate_reg <= RATE_NONE;
    end else begin
      rate_reg <= rate_next;
    end
  end

  assign rate_kbps_o = rate_reg;

endmodule : port_rate_decode

`default_nettype wire

// File: port_rate_limit_config.sv
// register bank for per-port ingress rate-limit settings, reached over apb
`default_nettype none

module port_rate_limit_config
  import rate_limit_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [rate_limit_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [rate_limit_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [rate_limit_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // per-port settings, index 0..11 = ports 4..15, 12 = port 24, 13 = port 25
  output logic [rate_limit_pkg::NUM_PORTS*rate_limit_pkg::THR_W-1:0] port_rate_threshold_o,
  output logic [rate_limit_pkg::NUM_PORTS-1:0] port_length_count_sel_o,
  output logic [rate_limit_pkg::NUM_PORTS-1:0] port_rate_limit_enable_o,
  output logic [rate_limit_pkg::NUM_PORTS*rate_limit_pkg::RATE_W-1:0] port_rate_kbps_o
);

  // ==========================================================================
  // state
  logic [15:0] rate_4_7_reg;
  logic [15:0] rate_8_11_reg;
  logic [15:0] rate_12_15_reg;
  logic [7:0] rate_24_25_reg;
  logic [15:0] enable_lo_reg;
  logic [EN_HI_W-1:0] enable_hi_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;

  // ==========================================================================
  // address decode
  logic hit_4_7;
  logic hit_8_11;
  logic hit_12_15;
  logic hit_24_25;
  logic hit_en_lo;
  logic hit_en_hi;
  logic addr_hit;
  logic setup;
  logic wr_en;

  assign hit_4_7 = paddr_i == ADDR_RATE_4_7;
  assign hit_8_11 = paddr_i == ADDR_RATE_8_11;
  assign hit_12_15 = paddr_i == ADDR_RATE_12_15;
  assign hit_24_25 = paddr_i == ADDR_RATE_24_25;
  assign hit_en_lo = paddr_i == ADDR_ENABLE_LO;
  assign hit_en_hi = paddr_i == ADDR_ENABLE_HI;
  assign addr_hit = hit_4_7 || hit_8_11 || hit_12_15 || hit_24_25 || hit_en_lo || hit_en_hi;

  apb_access u_apb (
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .addr_hit_i(addr_hit),
    .setup_o(setup),
    .wr_en_o(wr_en),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o)
  );

  // ==========================================================================
  // byte-lane merge; upper lanes 2 and 3 carry nothing
  logic [15:0] merge_4_7;
  logic [15:0] merge_8_11;
  logic [15:0] merge_12_15;
  logic [7:0] merge_24_25;
  logic [15:0] merge_en_lo;
  logic [EN_HI_W-1:0] merge_en_hi;

  assign merge_4_7 = {pstrb_i[1] ? pwdata_i[15:8] : rate_4_7_reg[15:8],
                      pstrb_i[0] ? pwdata_i[7:0] : rate_4_7_reg[7:0]};
  assign merge_8_11 = {pstrb_i[1] ? pwdata_i[15:8] : rate_8_11_reg[15:8],
                       pstrb_i[0] ? pwdata_i[7:0] : rate_8_11_reg[7:0]};
  assign merge_12_15 = {pstrb_i[1] ? pwdata_i[15:8] : rate_12_15_reg[15:8],
                        pstrb_i[0] ? pwdata_i[7:0] : rate_12_15_reg[7:0]};
  // bits 15:8 are reserved and never stored
  assign merge_24_25 = pstrb_i[0] ? pwdata_i[7:0] : rate_24_25_reg;
  assign merge_en_lo = {pstrb_i[1] ? pwdata_i[15:8] : enable_lo_reg[15:8],
                        pstrb_i[0] ? pwdata_i[7:0] : enable_lo_reg[7:0]};
  assign merge_en_hi = {pstrb_i[1] ? pwdata_i[9:8] : enable_hi_reg[9:8],
                        pstrb_i[0] ? pwdata_i[7:0] : enable_hi_reg[7:0]};

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rate_4_7_reg <= RATE_CFG_RST;
      rate_8_11_reg <= RATE_CFG_RST;
      rate_12_15_reg <= RATE_CFG_RST;
      rate_24_25_reg <= RATE_24_25_RST;
      enable_lo_reg <= ENABLE_LO_RST;
      enable_hi_reg <= ENABLE_HI_RST;
    end else if (wr_en) begin
      if (hit_4_7) rate_4_7_reg <= merge_4_7;
      if (hit_8_11) rate_8_11_reg <= merge_8_11;
      if (hit_12_15) rate_12_15_reg <= merge_12_15;
      if (hit_24_25) rate_24_25_reg <= merge_24_25;
      if (hit_en_lo) enable_lo_reg <= merge_en_lo;
      if (hit_en_hi) enable_hi_reg <= merge_en_hi;
    end
  end

  // ==========================================================================
  // read path, captured in setup so prdata comes from a flop in the access phase
  assign prdata_next = hit_4_7 ? {16'h0000, rate_4_7_reg} :
                       hit_8_11 ? {16'h0000, rate_8_11_reg} :
                       hit_12_15 ? {16'h0000, rate_12_15_reg} :
                       hit_24_25 ? {24'h000000, rate_24_25_reg} :
                       hit_en_lo ? {16'h0000, enable_lo_reg} :
                       hit_en_hi ? {22'h0, enable_hi_reg} :
                       32'h00000000;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prdata_reg <= 32'h00000000;
    end else if (setup && !pwrite_i) begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata_o = prdata_reg;

  // ==========================================================================
  // field extraction: every rate register shares the same nibble layout
  logic [NUM_PORTS*FIELD_W-1:0] all_fields;
  logic [NUM_PORTS-1:0] all_enables;

  // low nibble holds the lowest-numbered port, top nibble the highest
  assign all_fields = {rate_24_25_reg, rate_12_15_reg, rate_8_11_reg, rate_4_7_reg};
  // port 24 sits in the nibble the layout calls port 16
  assign all_enables = {enable_hi_reg[EN_HI_FIRST +: 2],
                        enable_lo_reg[EN_LO_FIRST +: 12]};

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign port_rate_threshold_o[p*THR_W +: THR_W] =
      all_fields[p*FIELD_W+THR_LSB +: THR_W];
    // 0 adds the packet length to the source port's own meter; 1 is stored as written
    assign port_length_count_sel_o[p] = all_fields[p*FIELD_W+LEN_BIT];
    assign port_rate_limit_enable_o[p] = all_enables[p];

    port_rate_decode u_dec (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .threshold_i(all_fields[p*FIELD_W+THR_LSB +: THR_W]),
      .enable_i(all_enables[p]),
      .rate_kbps_o(port_rate_kbps_o[p*RATE_W +: RATE_W])
    );
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_write_12_15;
    wr_en && hit_12_15 && pstrb_i[1:0] == 2'h3;
  endsequence

  sequence s_read_12_15;
    setup && !pwrite_i && hit_12_15;
  endsequence

  sequence s_write_4_7;
    wr_en && hit_4_7 && pstrb_i[1:0] == 2'h3;
  endsequence

  sequence s_read_4_7;
    setup && !pwrite_i && hit_4_7;
  endsequence

  a_reset_zero_thr: assert property (disable iff (1'b0)
    !nrst_i |=> rate_12_15_reg == 16'h0000 && port_rate_threshold_o == '0)
    else $error("threshold fields not zero after reset");

  a_code_to_rate: assert property (
    port_rate_limit_enable_o[0] && port_rate_threshold_o[2:0] == 3'h3
    |=> port_rate_kbps_o[RATE_W-1:0] == 15'h0200)
    else $error("code 011 did not give 512k");

  a_top_code_rate: assert property (
    port_rate_limit_enable_o[11] && port_rate_threshold_o[35:33] == 3'h7
    |=> port_rate_kbps_o[11*RATE_W +: RATE_W] == 15'h4e20)
    else $error("code 111 did not give 20M");

  a_disabled_no_rate: assert property (
    !port_rate_limit_enable_o[5] |=> port_rate_kbps_o[5*RATE_W +: RATE_W] == 15'h0000)
    else $error("disabled port still has a rate applied");

  a_write_readback: assert property (
    s_write_12_15 |=> rate_12_15_reg == $past(pwdata_i[15:0])
    && port_length_count_sel_o[11] == rate_12_15_reg[15]
    && port_rate_threshold_o[35:33] == rate_12_15_reg[14:12])
    else $error("ports 12-15 register did not store the written word");

  a_read_data: assert property (
    s_read_12_15 |=> prdata_o == {16'h0000, $past(rate_12_15_reg)})
    else $error("read of ports 12-15 register returned wrong data");

  a_layout_high: assert property (
    port_rate_threshold_o[11:9] == rate_4_7_reg[14:12]
    && port_length_count_sel_o[3] == rate_4_7_reg[15]
    && port_rate_threshold_o[14:12] == rate_8_11_reg[2:0])
    else $error("field layout mismatch in shared rate registers");

  a_len_sel_default: assert property (
    $rose(nrst_i) |-> port_length_count_sel_o == '0)
    else $error("length count select not zero after reset");

  a_reserved_zero: assert property (
    setup && !pwrite_i && hit_24_25 |=> prdata_o[31:8] == 24'h000000
    && prdata_o[7:0] == $past(rate_24_25_reg))
    else $error("ports 24/25 register reserved bits not zero");

  a_port24_fields: assert property (
    port_rate_threshold_o[38:36] == rate_24_25_reg[2:0]
    && port_rate_threshold_o[41:39] == rate_24_25_reg[6:4]
    && port_length_count_sel_o[13] == rate_24_25_reg[7])
    else $error("ports 24/25 fields in wrong bits");

  a_unmapped_err: assert property (
    psel_i && penable_i && !addr_hit |-> pslverr_o && pready_o)
    else $error("unmapped access not flagged");

  a_err_access_only: assert property (
    !(psel_i && penable_i) |-> !pslverr_o)
    else $error("error flagged outside an access phase");

  a_write_low_bank: assert property (
    s_write_4_7 |=> rate_4_7_reg == $past(pwdata_i[15:0]))
    else $error("ports 4-7 register did not store the written word");

  a_write_mid_bank: assert property (
    wr_en && hit_8_11 && pstrb_i[1:0] == 2'h3 |=> rate_8_11_reg == $past(pwdata_i[15:0]))
    else $error("ports 8-11 register did not store the written word");

  a_write_pair_bank: assert property (
    wr_en && hit_24_25 && pstrb_i[0] |=> rate_24_25_reg == $past(pwdata_i[7:0]))
    else $error("ports 24/25 register did not store the low byte");

  a_lane_keep: assert property (
    wr_en && hit_12_15 && !pstrb_i[1]
    |=> rate_12_15_reg[15:8] == $past(rate_12_15_reg[15:8]))
    else $error("unstrobed byte of ports 12-15 register changed");

  a_idle_keep: assert property (
    !wr_en |=> $stable(rate_4_7_reg) && $stable(rate_8_11_reg)
    && $stable(rate_12_15_reg) && $stable(rate_24_25_reg))
    else $error("rate register changed without a write");

  a_enable_write: assert property (
    wr_en && hit_en_hi && pstrb_i[1:0] == 2'h3 |=> enable_hi_reg == $past(pwdata_i[9:0]))
    else $error("enable high register did not store the written bits");

  a_enable_map: assert property (
    port_rate_limit_enable_o[0] == enable_lo_reg[4]
    && port_rate_limit_enable_o[11] == enable_lo_reg[15]
    && port_rate_limit_enable_o[13] == enable_hi_reg[9])
    else $error("port enable taken from the wrong bit");

  a_read_low_bank: assert property (
    s_read_4_7 |=> prdata_o == {16'h0000, $past(rate_4_7_reg)})
    else $error("read of ports 4-7 register returned wrong data");

  a_read_hold: assert property (
    !(setup && !pwrite_i) |=> $stable(prdata_o))
    else $error("read data changed outside a read setup");

  a_reset_rate_zero: assert property (disable iff (1'b0)
    !nrst_i |=> port_rate_kbps_o == '0 && port_rate_limit_enable_o == '0)
    else $error("rate outputs not zero after reset");

  a_lowest_code: assert property (
    port_rate_limit_enable_o[12] && port_rate_threshold_o[38:36] == THR_64K
    |=> port_rate_kbps_o[12*RATE_W +: RATE_W] == RATE_64K)
    else $error("code 000 did not give 64k");

  a_rate_128k: assert property (
    port_rate_limit_enable_o[2] && port_rate_threshold_o[8:6] == THR_128K
    |=> port_rate_kbps_o[2*RATE_W +: RATE_W] == RATE_128K)
    else $error("code 001 did not give 128k");

  a_rate_256k: assert property (
    port_rate_limit_enable_o[7] && port_rate_threshold_o[23:21] == THR_256K
    |=> port_rate_kbps_o[7*RATE_W +: RATE_W] == RATE_256K)
    else $error("code 010 did not give 256k");

  a_rate_1m: assert property (
    port_rate_limit_enable_o[9] && port_rate_threshold_o[29:27] == THR_1M
    |=> port_rate_kbps_o[9*RATE_W +: RATE_W] == RATE_1M)
    else $error("code 100 did not give 1M");

  a_rate_4m: assert property (
    port_rate_limit_enable_o[6] && port_rate_threshold_o[20:18] == THR_4M
    |=> port_rate_kbps_o[6*RATE_W +: RATE_W] == RATE_4M)
    else $error("code 101 did not give 4M");

  a_rate_10m: assert property (
    port_rate_limit_enable_o[13] && port_rate_threshold_o[41:39] == THR_10M
    |=> port_rate_kbps_o[13*RATE_W +: RATE_W] == RATE_10M)
    else $error("code 110 did not give 10M");

endmodule : port_rate_limit_config

`default_nettype wire

// File: dummy_end.sv
// intentionally empty compilation unit marker
`default_nettype none
`default_nettype wire

// File: port_rate_limit_config_tb.sv
// self-checking testbench for the port rate-limit configuration bank
`default_nettype none

module port_rate_limit_config_tb
  import rate_limit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // stimulus and observed signals
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [ADDR_W-1:0] paddr_i = 12'h000;
  logic [DATA_W-1:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'h0;
  logic [DATA_W-1:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [NUM_PORTS*THR_W-1:0] port_rate_threshold_o;
  logic [NUM_PORTS-1:0] port_length_count_sel_o;
  logic [NUM_PORTS-1:0] port_rate_limit_enable_o;
  logic [NUM_PORTS*RATE_W-1:0] port_rate_kbps_o;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  // register order: rates 4-7, 8-11, 12-15, 24/25, enable low, enable high
  logic [15:0] mdl [6];
  localparam logic [15:0] WMASK [6] = '{16'hffff, 16'hffff, 16'hffff, 16'h00ff, 16'hffff,
                                        16'h03ff};
  logic [ADDR_W-1:0] amap [6];

  port_rate_limit_config port_rate_limit_config_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .port_rate_threshold_o(port_rate_threshold_o),
    .port_length_count_sel_o(port_length_count_sel_o),
    .port_rate_limit_enable_o(port_rate_limit_enable_o),
    .port_rate_kbps_o(port_rate_kbps_o)
  );

  always #5 clk_i = ~clk_i;

  // ==========================================================================
  // hang guard; the whole run needs under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // ==========================================================================
  // compare and report
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_port(input logic [14:0] got, input logic [14:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: port got %h expected %h", $time, got, exp);
    end
  endtask : chk_port

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // apb master: holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // the wait ends once pready is seen; if it never comes, only the bench's hang guard ends it
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr_reg(input int r, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic err;
    apb(1'b1, amap[r], d, s, rd, err);
    chk_port({14'h0, err}, 15'h0);
    for (int b = 0; b < 2; b++) begin
      if (s[b]) mdl[r][8*b +: 8] = d[8*b +: 8] & WMASK[r][8*b +: 8];
    end
  endtask : wr_reg

  task automatic rd_reg(input int r);
    logic [31:0] rd;
    logic err;
    apb(1'b0, amap[r], $urandom, 4'h0, rd, err);
    chk_reg(rd, {16'h0, mdl[r]});
    chk_port({14'h0, err}, 15'h0);
  endtask : rd_reg

  // ==========================================================================
  // expected port values, worked out from the bank model
  function automatic logic [14:0] exp_rate(input logic [2:0] c, input logic en);
    logic [14:0] k [8] = '{15'd64, 15'd128, 15'd256, 15'd512, 15'd1000, 15'd4000,
                           15'd10000, 15'd20000};
    return en ? k[c] : 15'h0;
  endfunction : exp_rate

  task automatic chk_ports;
    logic [3:0] f;
    logic e;
    // rate outputs lag the register write by one edge
    repeat (3) @(posedge clk_i);
    for (int p = 0; p < NUM_PORTS; p++) begin
      f = (p < 12) ? mdl[p/4][(p%4)*4 +: 4] : mdl[3][(p-12)*4 +: 4];
      e = (p < 12) ? mdl[4][p+4] : mdl[5][p-4];
      chk_port({12'h0, port_rate_threshold_o[3*p +: 3]}, {12'h0, f[2:0]});
      chk_port({14'h0, port_length_count_sel_o[p]}, {14'h0, f[3]});
      chk_port({14'h0, port_rate_limit_enable_o[p]}, {14'h0, e});
      chk_port(port_rate_kbps_o[RATE_W*p +: RATE_W], exp_rate(f[2:0], e));
    end
  endtask : chk_ports

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] rd;
    logic err;
    amap = '{ADDR_RATE_4_7, ADDR_RATE_8_11, ADDR_RATE_12_15, ADDR_RATE_24_25,
             ADDR_ENABLE_LO, ADDR_ENABLE_HI};
    mdl = '{default: 16'h0};
    void'($urandom(73436));
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int r = 0; r < 6; r++) rd_reg(r);
    chk_ports();
    $display("test reset values done");
    // every code on every field, limiting on, upper lanes driven high but not strobed
    wr_reg(4, 32'hffff_fff0, 4'hf);
    wr_reg(5, 32'hffff_ffff, 4'hf);
    for (int c = 0; c < 8; c++) begin
      for (int r = 0; r < 4; r++) wr_reg(r, {16'hffff, {4{c[0], c[2:0]}}}, 4'h3);
      chk_ports();
      rd_reg(3);
    end
    $display("test threshold codes done");
    // random traffic with random byte strobes
    for (int i = 0; i < 80; i++) begin
      wr_reg($urandom_range(5, 0), $urandom, 4'($urandom_range(15, 0)));
      if (i % 3 == 0) rd_reg($urandom_range(5, 0));
      chk_ports();
    end
    $display("test random access done");
    // unmapped places: refused with an error, bank untouched
    foreach (amap[u]) begin
      // this offset lands clear of every mapped register
      apb(1'b1, amap[u] + 12'h100, 32'hffff_ffff, 4'hf, rd, err);
      chk_port({14'h0, err}, 15'h1);
      apb(1'b0, amap[u] + 12'h100, 32'h0, 4'h0, rd, err);
      chk_reg(rd, 32'h0);
      chk_port({14'h0, err}, 15'h1);
    end
    for (int r = 0; r < 6; r++) rd_reg(r);
    $display("test unmapped access done");
    // reset in mid-run returns every field to its default
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    mdl = '{default: 16'h0};
    chk_ports();
    for (int r = 0; r < 6; r++) rd_reg(r);
    $display("test second reset done");
    wrap_up();
  end

endmodule : port_rate_limit_config_tb

`default_nettype wire
